// *** inc/imv_params.svh ***
// offsets, reset values and vector locations of the interrupt mask block
`ifndef IMV_PARAMS_SVH
`define IMV_PARAMS_SVH
`define IMV_OFS_MASK 4'h0
`define IMV_OFS_PEND 4'h4
`define IMV_MASK_RST 8'h00
`define IMV_IMPL_MC 8'hE3
`define IMV_IMPL_ALL 8'hFF
`define IMV_VEC_NMI 16'h203E
`define IMV_VEC_EXT 16'h203C
`define IMV_VEC_MUX 16'h203A
`define IMV_VEC_B4 16'h2038
`define IMV_VEC_B3 16'h2036
`define IMV_VEC_B2 16'h2034
`define IMV_VEC_B1 16'h2032
`define IMV_VEC_B0 16'h2030
`define IMV_RESP_OKAY 2'h0
`define IMV_RESP_SLVERR 2'h2
`endif

// *** inc/imv_pkg.sv ***
// types shared by the interrupt mask block
package imv_pkg;
    typedef enum logic [1:0] {IMV_MC, IMV_MD, IMV_MH} imv_variant_t;
    typedef struct packed {
        logic pend;
        logic fwd;
    } imv_gate_st_t;
    typedef struct packed {
        logic [7:0] mask;
        logic aw_full;
        logic [3:0] awaddr;
        logic w_full;
        logic [7:0] wdata;
        logic wbyte;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [15:0] vec_addr;
        logic vec_valid;
    } imv_st_t;
endpackage

// *** rtl/imv_gate.sv ***
// one interrupt source: sticky pending flag gated by its mask bit
`timescale 1ns/1ps
module imv_gate (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // source side
    input wire logic req,
    input wire logic ack,
    input wire logic en,
    // status and forwarded request
    output logic pend,
    output logic fwd
);
    import imv_pkg::*;
    imv_gate_st_t st_ff;
    imv_gate_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        // a new request beats an acknowledge in the same cycle
        nxt_st.pend = req | (st_ff.pend & ~ack);
        // masking only hides the request, the pending flag survives
        nxt_st.fwd = nxt_st.pend & en;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pend = st_ff.pend;
    assign fwd = st_ff.fwd;
endmodule

// *** rtl/imv_top.sv ***
// interrupt enable mask, pending gates and vector lookup with axi4-lite
//
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "imv_params.svh"
module imv_top #(
    parameter imv_pkg::imv_variant_t VARIANT = imv_pkg::IMV_MD
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // axi4-lite write address and data
    input wire logic [3:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    // axi4-lite write response
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // axi4-lite read
    input wire logic [3:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // interrupt sources, bit 7 the NMI input (gated by its mask bit like the rest) down to bit 0
    input wire logic [7:0] irq_req,
    input wire logic [7:0] irq_ack,
    output logic [7:0] irq_fwd,
    // vector lookup for the source being serviced
    input wire logic svc_valid,
    input wire logic [2:0] svc_idx,
    output logic [15:0] vec_addr,
    output logic vec_valid
);
    import imv_pkg::*;
    // bits 4..2 have no source on the two-channel variant
    localparam logic [7:0] IMPL =
        (VARIANT == IMV_MC) ? `IMV_IMPL_MC : `IMV_IMPL_ALL;

    imv_st_t st_ff;
    imv_st_t nxt_st;
    logic [7:0] pend;
    logic do_wr;

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : gen_src
            imv_gate u_gate (
                .clk(clk),
                .rst_n(rst_n),
                .req(irq_req[g] & IMPL[g]),
                .ack(irq_ack[g]),
                .en(st_ff.mask[g]),
                .pend(pend[g]),
                .fwd(irq_fwd[g])
            );
        end
    endgenerate

    assign do_wr = st_ff.aw_full & st_ff.w_full & ~st_ff.bvalid;

    always_comb begin
        nxt_st = st_ff;
        if (s_awvalid && st_ff.awready) begin
            nxt_st.aw_full = 1'b1;
            nxt_st.awaddr = s_awaddr;
        end
        if (s_wvalid && st_ff.wready) begin
            nxt_st.w_full = 1'b1;
            nxt_st.wdata = s_wdata[7:0];
            nxt_st.wbyte = s_wstrb[0];
        end
        if (st_ff.bvalid && s_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        // address and data may arrive in either order; act once both held
        if (do_wr) begin
            nxt_st.aw_full = 1'b0;
            nxt_st.w_full = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = `IMV_RESP_OKAY;
            if (st_ff.awaddr == `IMV_OFS_MASK) begin
                // store with bits that have no source cleared, nothing else happens on a mask write
                if (st_ff.wbyte) begin
                    nxt_st.mask = st_ff.wdata & IMPL;
                end
            end else if (st_ff.awaddr != `IMV_OFS_PEND) begin
                nxt_st.bresp = `IMV_RESP_SLVERR;
            end
        end
        nxt_st.awready = ~nxt_st.aw_full;
        nxt_st.wready = ~nxt_st.w_full;
        if (st_ff.rvalid && s_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (s_arvalid && st_ff.arready) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = `IMV_RESP_OKAY;
            nxt_st.rdata = 32'h0000_0000;
            case (s_araddr)
                `IMV_OFS_MASK: nxt_st.rdata[7:0] = st_ff.mask;
                `IMV_OFS_PEND: nxt_st.rdata[7:0] = pend;
                default: nxt_st.rresp = `IMV_RESP_SLVERR;
            endcase
        end
        nxt_st.arready = ~nxt_st.rvalid;
        nxt_st.vec_valid = svc_valid;
        if (svc_valid) begin
            case (svc_idx)
                3'd7: nxt_st.vec_addr = `IMV_VEC_NMI;
                3'd6: nxt_st.vec_addr = `IMV_VEC_EXT;
                3'd5: nxt_st.vec_addr = `IMV_VEC_MUX;
                3'd4: nxt_st.vec_addr = `IMV_VEC_B4;
                3'd3: nxt_st.vec_addr = `IMV_VEC_B3;
                3'd2: nxt_st.vec_addr = `IMV_VEC_B2;
                3'd1: nxt_st.vec_addr = `IMV_VEC_B1;
                default: nxt_st.vec_addr = `IMV_VEC_B0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
            st_ff.mask <= `IMV_MASK_RST;
            st_ff.awready <= 1'b1;
            st_ff.wready <= 1'b1;
            st_ff.arready <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign s_awready = st_ff.awready;
    assign s_wready = st_ff.wready;
    assign s_bvalid = st_ff.bvalid;
    assign s_bresp = st_ff.bresp;
    assign s_arready = st_ff.arready;
    assign s_rvalid = st_ff.rvalid;
    assign s_rdata = st_ff.rdata;
    assign s_rresp = st_ff.rresp;
    assign vec_addr = st_ff.vec_addr;
    assign vec_valid = st_ff.vec_valid;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    fwd_needs_mask_a: assert property (
        ##1 ((irq_fwd & ~$past(st_ff.mask)) == 8'h00))
        else $error("request forwarded while masked");
    pend_kept_a: assert property (
        ##1 (($past(pend) & ~$past(irq_ack) & ~pend) == 8'h00))
        else $error("pending request lost without acknowledge");
    mask_store_a: assert property (
        (do_wr && st_ff.awaddr == `IMV_OFS_MASK && st_ff.wbyte)
        |=> (st_ff.mask == ($past(st_ff.wdata) & IMPL)) && s_bvalid)
        else $error("mask write not stored");
    mask_read_a: assert property (
        (s_arvalid && s_arready && s_araddr == `IMV_OFS_MASK)
        |=> s_rvalid && s_rdata == {24'h00_0000, $past(st_ff.mask)})
        else $error("mask read returned wrong value");
    vec_top_a: assert property (
        (svc_valid && svc_idx >= 3'd5) |=> vec_valid &&
        vec_addr == 16'h2030 + {12'h000, $past(svc_idx), 1'b0})
        else $error("wrong vector for upper sources");
    vec_b4_a: assert property (
        (svc_valid && svc_idx == 3'd4) |=> vec_addr == 16'h2038)
        else $error("wrong vector for bit 4");
    vec_b3_a: assert property (
        (svc_valid && svc_idx == 3'd3) |=> vec_addr == 16'h2036)
        else $error("wrong vector for bit 3");
    vec_b2_a: assert property (
        (svc_valid && svc_idx == 3'd2) |=> vec_addr == 16'h2034)
        else $error("wrong vector for bit 2");
    vec_b1_a: assert property (
        (svc_valid && svc_idx == 3'd1) |=> vec_addr == 16'h2032)
        else $error("wrong vector for bit 1");
    vec_b0_a: assert property (
        (svc_valid && svc_idx == 3'd0) |=> vec_addr == 16'h2030)
        else $error("wrong vector for bit 0");

    // the bus must not withdraw an answer before the master takes it
    bresp_hold_a: assert property (
        (s_bvalid && !s_bready) |=> s_bvalid && $stable(s_bresp))
        else $error("write response withdrawn before taken");
    rdata_hold_a: assert property (
        (s_rvalid && !s_rready) |=> s_rvalid && $stable(s_rdata))
        else $error("read data withdrawn before taken");

    // every cycle of a live request on a bit with a source must leave a pending flag behind
    pend_set_a: assert property (
        ##1 ((($past(irq_req) & IMPL) & ~pend) == 8'h00))
        else $error("request did not set pending");
    // a bit without a source can never be enabled
    unimpl_mask_a: assert property (
        (st_ff.mask & ~IMPL) == 8'h00)
        else $error("mask bit set without a source");
    // a vector is only offered for a lookup made one cycle earlier
    vec_pulse_a: assert property (
        vec_valid |-> $past(svc_valid))
        else $error("vector offered without a lookup");

    mask_write_c: cover property (do_wr && st_ff.awaddr == `IMV_OFS_MASK);
    held_masked_c: cover property ((pend & ~st_ff.mask) != 8'h00);
    vec_fetch_c: cover property (svc_valid ##1 vec_valid);
    // a held request released by unmasking, and a refused read
    unmask_fwd_c: cover property (
        !st_ff.mask[1] ##1 st_ff.mask[1] ##1 irq_fwd[1]);
    read_err_c: cover property (s_rvalid && s_rresp == `IMV_RESP_SLVERR);
endmodule

// *** sim/testbench.sv ***
// self-checking bench for the interrupt mask block over axi4-lite
`timescale 1ns/1ps
`include "imv_params.svh"
module testbench;
    import imv_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] s_awaddr = 4'h0, s_araddr = 4'h0, s_wstrb = 4'h0;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
    logic s_arvalid = 1'b0, s_rready = 1'b0, svc_valid = 1'b0;
    logic [31:0] s_wdata = 32'h0000_0000;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, vec_valid;
    logic [1:0] s_bresp, s_rresp, resp;
    logic [31:0] s_rdata, rd;
    logic [7:0] irq_req = 8'h00, irq_ack = 8'h00, irq_fwd;
    logic [2:0] svc_idx = 3'h0;
    logic [15:0] vec_addr;
    logic [31:0] mc_rdata, rd_mc, exp_v;
    logic [7:0] mc_fwd;
    logic [15:0] mc_vaddr;
    logic mc_vvalid;
    int fails = 0;
    int checked = 0;
    imv_top u_imv_top (.clk(clk), .rst_n(rst_n), .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
        .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
        .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
        .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
        .s_rready(s_rready), .irq_req(irq_req), .irq_ack(irq_ack),
        .irq_fwd(irq_fwd), .svc_valid(svc_valid), .svc_idx(svc_idx),
        .vec_addr(vec_addr), .vec_valid(vec_valid));
    // two-channel variant on the same bus: only bits 7..5, 1, 0 exist
    imv_top #(.VARIANT(IMV_MC)) u_imv_top_mc (.clk(clk), .rst_n(rst_n),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(),
        .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
        .s_wready(), .s_bresp(), .s_bvalid(), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(),
        .s_rdata(mc_rdata), .s_rresp(), .s_rvalid(), .s_rready(s_rready),
        .irq_req(irq_req), .irq_ack(irq_ack), .irq_fwd(mc_fwd),
        .svc_valid(svc_valid), .svc_idx(svc_idx), .vec_addr(mc_vaddr),
        .vec_valid(mc_vvalid));
    always #10 clk = ~clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // address and data are offered together and dropped as each is taken
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        s_awaddr <= a;
        s_awvalid <= 1'b1;
        s_wdata <= d;
        s_wstrb <= 4'h1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
        end while (s_bvalid !== 1'b1);
        resp = s_bresp;
        s_bready <= 1'b0;
    endtask
    task automatic rdr(input logic [3:0] a);
        @(posedge clk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_arready) s_arvalid <= 1'b0;
        end while (s_rvalid !== 1'b1);
        rd = s_rdata;
        rd_mc = mc_rdata;
        resp = s_rresp;
        s_rready <= 1'b0;
    endtask
    task automatic tally_and_finish;
        if (fails == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        tally_and_finish;
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdr(`IMV_OFS_MASK);
        chk(rd, {24'h00_0000, `IMV_MASK_RST});
        chk(rd_mc, {24'h00_0000, `IMV_MASK_RST});
        wr(`IMV_OFS_MASK, 32'hFFFF_FFA5);
        chk({30'h0, resp}, {30'h0, `IMV_RESP_OKAY});
        // neither a pending-status write nor a stray address may touch it
        wr(`IMV_OFS_PEND, 32'h0000_00FF);
        chk({30'h0, resp}, {30'h0, `IMV_RESP_OKAY});
        wr(4'hC, 32'h0000_00FF);
        chk({30'h0, resp}, {30'h0, `IMV_RESP_SLVERR});
        rdr(`IMV_OFS_MASK);
        chk(rd, 32'h0000_00A5);
        // two-channel variant keeps only the bits that have a source
        chk(rd_mc, 32'h0000_00A1);
        rdr(4'h8);
        chk({30'h0, resp}, {30'h0, `IMV_RESP_SLVERR});
        // pulse every source once; only unmasked ones may reach priority
        @(posedge clk);
        irq_req <= 8'hFF;
        @(posedge clk);
        irq_req <= 8'h00;
        repeat (2) @(posedge clk);
        chk({24'h0, irq_fwd}, 32'h0000_00A5);
        chk({24'h0, mc_fwd}, 32'h0000_00A1);
        rdr(`IMV_OFS_PEND);
        chk(rd, 32'h0000_00FF);
        chk(rd_mc, 32'h0000_00E3);
        wr(`IMV_OFS_MASK, 32'h0000_005A);
        repeat (2) @(posedge clk);
        chk({24'h0, irq_fwd}, 32'h0000_005A);
        chk({24'h0, mc_fwd}, 32'h0000_0042);
        irq_ack <= 8'hFF;
        @(posedge clk);
        irq_ack <= 8'h00;
        repeat (2) @(posedge clk);
        chk({24'h0, irq_fwd}, 32'h0000_0000);
        chk({24'h0, mc_fwd}, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            svc_valid <= 1'b1;
            svc_idx <= 3'(i);
            @(posedge clk);
            svc_valid <= 1'b0;
            @(posedge clk);
            exp_v = {16'h0001, 16'h2030 + 16'(2 * i)};
            chk({15'h0, vec_valid, vec_addr}, exp_v);
            chk({15'h0, mc_vvalid, mc_vaddr}, exp_v);
        end
        tally_and_finish;
    end
endmodule
